// file: tkmoc_host.sv
// host model: option bus master and serial key frame reader
module tkmoc_host import tkmoc_pkg::*; #(
  parameter int TICK = 2 // cycles per ms tick
) (
  input wire logic clk, // system clock
  input wire logic sda_oe, // device pulls option data low
  input wire logic data_oe, // device pulls serial data low
  output logic scl, // option bus clock
  output logic sda, // resolved option data wire
  output logic link_clk // serial clock, idles high
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_low;
  // ==========================================================
  // pull-up wire: low while either party drives it
  assign sda = ~(drv_low | sda_oe);
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
    link_clk = 1'b1;
  end
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  task automatic put_bit(input logic b, output logic r);
    drv_low = ~b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic edge_c(input logic stop);
    drv_low = stop;
    half();
    scl = 1'b1;
    half();
    drv_low = ~stop;
    half();
    if (!stop) scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic a,
                       output logic [7:0] rx);
    logic ak;
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(a, ak);
  endtask
  // ==========================================================
  // each access takes microseconds, far inside the access window
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rx;
    edge_c(1'b0);
    xbyte({BUS_ADDR_DFLT, 1'b0}, 1'b0, rx);
    xbyte(a, 1'b0, rx);
    xbyte(d, 1'b0, rx);
    edge_c(1'b1);
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] rx;
    edge_c(1'b0);
    xbyte({BUS_ADDR_DFLT, 1'b0}, 1'b0, rx);
    xbyte(a, 1'b0, rx);
    edge_c(1'b1);
    edge_c(1'b0);
    xbyte({BUS_ADDR_DFLT, 1'b1}, 1'b0, rx);
    xbyte(8'hFF, 1'b1, d);
    edge_c(1'b1);
  endtask
  // ==========================================================
  // sample late in the high phase: the bit lands some ns after a fall
  task automatic read_frame(output logic [15:0] f);
    #1000;
    // phases shrink with the ms tick; the design needs a few clk each
    for (int i = 0; i < 16; i++) begin
      link_clk = 1'b0;
      #32;
      link_clk = 1'b1;
      #31;
      f[i] = ~data_oe;
      #1;
    end
    repeat (6 * TICK) @(negedge clk);
  endtask
endmodule

// file: tkmoc_pkg.sv
// shared constants and types of the touch-key mode and option control block
package tkmoc_pkg;
  // ==========================================================
  // clock and time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int TICK_CYC_DFLT = MS_NS / CLK_PERIOD_NS; // cycles per ms
  localparam int NUM_KEYS = 8;
  // ==========================================================
  // times in milliseconds, counted on the 1 ms tick
  localparam logic [15:0] NORMAL_TO_STANDBY_MS = 16'h1F40; // 8000
  localparam logic [15:0] RESP_NORMAL_MS = 16'h007D; // 125
  localparam logic [15:0] RESP_STANDBY_MS = 16'h0096; // 150
  localparam logic [15:0] RESP_SAVE_MS = 16'h0258; // 600
  localparam logic [15:0] MAX_KEY_HOLD_MS = 16'hFA00; // 64000
  localparam logic [15:0] CAL_NORMAL_MS = 16'h03E8; // 1000
  localparam logic [15:0] CAL_STANDBY_MS = 16'h7D00; // 32000
  localparam logic [15:0] BUS_TIMEOUT_MS = 16'h0040; // 64
  localparam logic [15:0] ONE_SHOT_MS = 16'h0001; // 1
  // ==========================================================
  // option registers
  localparam logic [7:0] OFF_IRQ_STYLE = 8'hB0;
  localparam logic [7:0] OFF_POWER_SAVE = 8'hB4;
  localparam logic [7:0] OFF_KEY_BASE = 8'hB5;
  localparam int STYLE_BIT = 0;
  localparam int SAVE_BIT = 6;
  localparam int WAKE_BIT = 7;
  localparam logic [7:0] STYLE_MASK = 8'h01;
  localparam logic [7:0] SAVE_MASK = 8'h40;
  localparam logic [7:0] KEY_MASK = 8'hBF;
  localparam logic [7:0] STYLE_RST = 8'h00;
  localparam logic [7:0] SAVE_RST = 8'h40;
  localparam logic [7:0] KEY_CFG_RST = 8'h90;
  // device address on the option bus, value arbitrary
  localparam logic [6:0] BUS_ADDR_DFLT = 7'h50;
  // ==========================================================
  // serial key frame
  localparam logic [3:0] FRAME_STOP = 4'hA;
  localparam logic [3:0] FRAME_LAST = 4'hF;
  typedef enum logic {TKMOC_NORMAL, TKMOC_STANDBY} tkmoc_mode_type;
  typedef enum logic [2:0] {
    TKMOC_IDLE, TKMOC_ADDR, TKMOC_PTR, TKMOC_WR, TKMOC_RD
  } tkmoc_bus_type;
endpackage

// file: tkmoc_top.sv
// touch-key mode, timing and option control with key report links
// Behaviour
// R1: idle 8 s after power-on enters standby
// R2: touch in standby wakes, report until release
// R3: all released, back to standby after 8 s
// R4: per-key wake enable gates standby wake-up
// R5: normal mode touch response 125 ms
// R6: standby response 150 ms, 600 ms strong saving
// R7: held key forced off after 64 s
// R8: calibrate every 1 s normal, 32 s standby
// R9: host waits 6 ms after failed read
// R10: host finishes option access within 6 s
// R11: 0xB0 bit0 selects level or one-shot interrupt
// R12: 0xB4 bit6 selects standby power saving
// R13: per-key register: wake, zero, threshold
// R14: strap picks open-drain low or push-pull high
// R15: strap picks serial or binary key output
// R16: saving strap grounded gives stronger saving
// R17: option bus idle 64 ms abandons transfer
// R18: host serial clock phases at least 20 us
module tkmoc_top import tkmoc_pkg::*; #(
  parameter int TICK_CYC = TICK_CYC_DFLT, // cycles per ms tick
  parameter logic [6:0] BUS_ADDR = BUS_ADDR_DFLT // arbitrary address
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, low
  input wire logic [7:0] key_touch, // raw touch detect per key
  input wire logic output_mode_select_n, // strap, low = tied
  input wire logic low_standby_current_select_n, // strap, low = tied
  input wire logic link_clk, // host serial clock
  input wire logic scl_i, // option bus clock in
  input wire logic sda_i, // option bus data in
  output logic sda_o, // option bus data out
  output logic sda_oe, // option bus data drive
  output logic data_o, // serial data pin out
  output logic data_oe, // serial data pin drive
  output logic [7:0] key_out_o, // parallel key outputs
  output logic [7:0] key_out_oe, // parallel output drives
  output logic [3:0] bin_code_o, // binary coded key
  output logic irq_n, // interrupt, low active
  output logic cal_pulse, // calibration strobe
  output logic standby_o // standby mode flag
);
  // ==========================================================
  // synchronisers and straps
  logic [13:0] sync1_reg, sync2_reg;
  logic [1:0] bus_prev_reg;
  logic straps_done_reg, mode_tied_reg, save_tied_reg;
  logic [1:0] fill_cnt_reg;
  logic link_low, link_busy;
  logic [7:0] key_raw;
  logic scl_s, sda_s, link_low_s, busy_s;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      bus_prev_reg <= 2'h3;
    end else begin
      sync1_reg <= {key_touch, output_mode_select_n,
                    low_standby_current_select_n, scl_i, sda_i,
                    link_low, link_busy};
      sync2_reg <= sync1_reg;
      bus_prev_reg <= {scl_s, sda_s};
    end
  end
  assign key_raw = sync2_reg[13:6];
  assign scl_s = sync2_reg[3];
  assign sda_s = sync2_reg[2];
  assign link_low_s = sync2_reg[1];
  assign busy_s = sync2_reg[0];
  // straps are caught once, after the synchroniser has filled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      straps_done_reg <= 1'b0;
      mode_tied_reg <= 1'b0;
      save_tied_reg <= 1'b0;
      fill_cnt_reg <= '0;
    end else begin
      // reset contents of the synchroniser must never be taken as straps
      if (fill_cnt_reg != 2'h3) fill_cnt_reg <= fill_cnt_reg + 2'h1;
      if (!straps_done_reg && fill_cnt_reg == 2'h3 &&
          bus_prev_reg == 2'h3) begin
        straps_done_reg <= 1'b1;
        mode_tied_reg <= ~sync2_reg[5];
        save_tied_reg <= ~sync2_reg[4];
      end
    end
  end
  // ==========================================================
  // millisecond tick
  logic [16:0] tick_cnt_reg;
  logic tick;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) tick_cnt_reg <= '0;
    else if (tick) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick_cnt_reg + 17'h00001;
  end
  assign tick = (tick_cnt_reg == 17'(TICK_CYC - 1));
  // ==========================================================
  // option registers
  logic [7:0] style_reg, save_reg;
  logic [7:0] key_cfg_reg [NUM_KEYS];
  logic wr_stb_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic [7:0] wake_en;
  logic low_save;
  function automatic logic key_hit(input logic [7:0] a);
    return (a >= OFF_KEY_BASE) && (a < OFF_KEY_BASE + 8'h08);
  endfunction
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    logic [7:0] idx;
    idx = a - OFF_KEY_BASE;
    if (a == OFF_IRQ_STYLE) return style_reg;
    if (a == OFF_POWER_SAVE) return save_reg;
    if (key_hit(a)) return key_cfg_reg[idx[2:0]];
    return 8'h00;
  endfunction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      style_reg <= STYLE_RST;
      save_reg <= SAVE_RST;
      for (int i = 0; i < NUM_KEYS; i++) key_cfg_reg[i] <= KEY_CFG_RST;
    end else if (wr_stb_reg) begin
      if (wr_addr_reg == OFF_IRQ_STYLE)
        style_reg <= wr_data_reg & STYLE_MASK; // R11
      if (wr_addr_reg == OFF_POWER_SAVE)
        save_reg <= wr_data_reg & SAVE_MASK; // R12
      if (key_hit(wr_addr_reg))
        key_cfg_reg[3'(wr_addr_reg - OFF_KEY_BASE)] <=
          wr_data_reg & KEY_MASK; // R13
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_KEYS; i++) wake_en[i] = key_cfg_reg[i][WAKE_BIT];
  end
  // either the strap or the register asks for the stronger saving
  assign low_save = save_reg[SAVE_BIT] | save_tied_reg; // R12 R16
  // ==========================================================
  // key response, hold limit and mode
  tkmoc_mode_type mode_reg;
  logic [7:0] key_rep_reg, key_prev_reg, hold_block_reg, key_cand;
  logic [15:0] deb_cnt_reg, hold_cnt_reg, idle_cnt_reg, resp_ms;
  always_comb begin
    key_cand = key_raw & ~hold_block_reg; // R7
    resp_ms = RESP_NORMAL_MS; // R5
    if (mode_reg == TKMOC_STANDBY) begin
      key_cand = key_cand & wake_en; // R4
      resp_ms = low_save ? RESP_SAVE_MS : RESP_STANDBY_MS; // R6
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      deb_cnt_reg <= '0;
      key_rep_reg <= '0;
      key_prev_reg <= '0;
    end else begin
      key_prev_reg <= key_cand;
      if (key_cand == key_rep_reg || key_cand != key_prev_reg)
        deb_cnt_reg <= '0;
      else if (tick) begin
        if (deb_cnt_reg >= resp_ms - 16'h0001) begin
          key_rep_reg <= key_cand; // R5 R6
          deb_cnt_reg <= '0;
        end else deb_cnt_reg <= deb_cnt_reg + 16'h0001;
      end
    end
  end
  // a key blocked by the hold limit stays off until it is let go
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_reg <= '0;
      hold_block_reg <= '0;
    end else begin
      if (key_rep_reg == 8'h00 || key_rep_reg != key_cand)
        hold_cnt_reg <= '0;
      else if (tick) hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      if (tick && hold_cnt_reg == MAX_KEY_HOLD_MS - 16'h0001)
        hold_block_reg <= key_rep_reg; // R7
      else hold_block_reg <= hold_block_reg & key_raw;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) idle_cnt_reg <= '0;
    else if (key_rep_reg != 8'h00 || mode_reg == TKMOC_STANDBY)
      idle_cnt_reg <= '0;
    else if (tick) idle_cnt_reg <= idle_cnt_reg + 16'h0001;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) mode_reg <= TKMOC_NORMAL; // R1
    else begin
      unique case (mode_reg)
        TKMOC_NORMAL: begin
          if (tick && key_rep_reg == 8'h00 &&
              idle_cnt_reg == NORMAL_TO_STANDBY_MS - 16'h0001)
            mode_reg <= TKMOC_STANDBY; // R1 R3
        end
        TKMOC_STANDBY: begin
          if (key_rep_reg != 8'h00) mode_reg <= TKMOC_NORMAL; // R2
        end
      endcase
    end
  end
  // ==========================================================
  // calibration period
  logic [15:0] cal_cnt_reg;
  tkmoc_mode_type cal_mode_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cal_cnt_reg <= '0;
      cal_pulse <= 1'b0;
      cal_mode_reg <= TKMOC_NORMAL;
    end else begin
      cal_mode_reg <= mode_reg;
      cal_pulse <= 1'b0;
      if (cal_mode_reg != mode_reg) cal_cnt_reg <= '0;
      else if (tick) begin
        if (cal_cnt_reg == (mode_reg == TKMOC_NORMAL ? CAL_NORMAL_MS
                            : CAL_STANDBY_MS) - 16'h0001) begin
          cal_cnt_reg <= '0;
          cal_pulse <= 1'b1; // R8
        end else cal_cnt_reg <= cal_cnt_reg + 16'h0001;
      end
    end
  end
  // ==========================================================
  // interrupt, parallel and binary outputs
  logic shot_reg;
  logic [7:0] rep_last_reg;
  function automatic logic [3:0] key_count(input logic [7:0] k);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < NUM_KEYS; i++) n = n + {3'h0, k[i]};
    return n;
  endfunction
  function automatic logic [3:0] lowest_key(input logic [7:0] k);
    logic [3:0] n;
    n = 4'h0;
    for (int i = NUM_KEYS - 1; i >= 0; i--) if (k[i]) n = 4'(i + 1);
    return n;
  endfunction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rep_last_reg <= '0;
      shot_reg <= 1'b0;
      irq_n <= 1'b1;
    end else begin
      rep_last_reg <= key_rep_reg;
      if (rep_last_reg != key_rep_reg) shot_reg <= 1'b1;
      else if (tick) shot_reg <= 1'b0;
      irq_n <= style_reg[STYLE_BIT] ? ~shot_reg
               : (key_rep_reg == 8'h00); // R11
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      key_out_o <= '0;
      key_out_oe <= '0;
      bin_code_o <= '0;
      standby_o <= 1'b0;
    end else begin
      standby_o <= (mode_reg == TKMOC_STANDBY);
      key_out_o <= mode_tied_reg ? key_rep_reg : 8'h00; // R14
      key_out_oe <= mode_tied_reg ? 8'hFF : key_rep_reg; // R14
      bin_code_o <= mode_tied_reg ? lowest_key(key_rep_reg) : 4'h0; // R15
    end
  end
  // ==========================================================
  // serial key frame, main side
  logic [15:0] frame_hold_reg;
  logic start_pend_reg;
  // the frame copy freezes while the link is busy; the start bit gives
  // the host ms of settling before its first edge samples the copy
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_hold_reg <= {FRAME_STOP, 4'h0, 8'hFF};
      start_pend_reg <= 1'b0;
      data_oe <= 1'b0;
    end else begin
      if (!busy_s)
        frame_hold_reg <= {FRAME_STOP, key_count(key_rep_reg), ~key_rep_reg};
      if (rep_last_reg != key_rep_reg && !mode_tied_reg)
        start_pend_reg <= 1'b1; // R15
      else if (busy_s) start_pend_reg <= 1'b0;
      data_oe <= link_low_s | (start_pend_reg & ~busy_s);
    end
  end
  assign data_o = 1'b0;
  // ==========================================================
  // serial key frame, link side; shifts on the host's falling edge
  logic [3:0] bit_cnt_reg;
  logic [15:0] link_sh_reg;
  logic link_low_reg, link_busy_reg;
  always_ff @(negedge link_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_reg <= '0;
      link_sh_reg <= '0;
      link_low_reg <= 1'b0;
      link_busy_reg <= 1'b0;
    end else begin
      if (bit_cnt_reg == 4'h0) begin
        link_sh_reg <= {1'b0, frame_hold_reg[15:1]};
        link_low_reg <= ~frame_hold_reg[0];
        link_busy_reg <= 1'b1;
      end else begin
        link_sh_reg <= {1'b0, link_sh_reg[15:1]};
        link_low_reg <= ~link_sh_reg[0];
      end
      if (bit_cnt_reg == FRAME_LAST) link_busy_reg <= 1'b0;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end
  assign link_low = link_low_reg;
  assign link_busy = link_busy_reg;
  // ==========================================================
  // option bus slave
  tkmoc_bus_type bus_reg;
  logic [3:0] bcnt_reg;
  logic [7:0] sh_reg, tx_reg, ptr_reg;
  logic ack_reg;
  logic [15:0] to_cnt_reg;
  logic scl_rise, scl_fall, bus_start, bus_stop, bus_edge;
  logic [7:0] rd_byte;
  always_comb rd_byte = reg_read(ptr_reg);
  assign scl_rise = scl_s & ~bus_prev_reg[1];
  assign scl_fall = ~scl_s & bus_prev_reg[1];
  assign bus_start = scl_s & bus_prev_reg[1] & ~sda_s & bus_prev_reg[0];
  assign bus_stop = scl_s & bus_prev_reg[1] & sda_s & ~bus_prev_reg[0];
  assign bus_edge = (bus_prev_reg != {scl_s, sda_s});
  assign sda_o = 1'b0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) to_cnt_reg <= '0;
    else if (bus_edge || bus_reg == TKMOC_IDLE) to_cnt_reg <= '0;
    else if (tick) to_cnt_reg <= to_cnt_reg + 16'h0001;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_reg <= TKMOC_IDLE;
      bcnt_reg <= '0;
      sh_reg <= '0;
      tx_reg <= '0;
      ptr_reg <= '0;
      ack_reg <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_stb_reg <= 1'b0;
      if (bus_start) begin
        bus_reg <= TKMOC_ADDR;
        bcnt_reg <= '0;
        ack_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop || to_cnt_reg >= BUS_TIMEOUT_MS) begin
        bus_reg <= TKMOC_IDLE; // R17
        sda_oe <= 1'b0;
      end else if (scl_rise && bus_reg == TKMOC_RD) begin
        if (bcnt_reg != 4'h8) bcnt_reg <= bcnt_reg + 4'h1;
        else if (sda_s) bus_reg <= TKMOC_IDLE;
        else begin
          bcnt_reg <= '0;
          ptr_reg <= ptr_reg + 8'h01;
          tx_reg <= reg_read(ptr_reg + 8'h01);
        end
      end else if (scl_rise && !ack_reg && bus_reg != TKMOC_IDLE) begin
        sh_reg <= {sh_reg[6:0], sda_s};
        bcnt_reg <= bcnt_reg + 4'h1;
      end else if (scl_fall && ack_reg) begin
        ack_reg <= 1'b0;
        sda_oe <= 1'b0;
        if (bus_reg == TKMOC_RD) begin
          sda_oe <= ~rd_byte[7];
          tx_reg <= {rd_byte[6:0], 1'b0};
          bcnt_reg <= '0;
        end
      end else if (scl_fall && bus_reg == TKMOC_RD) begin
        sda_oe <= (bcnt_reg < 4'h8) & ~tx_reg[7];
        tx_reg <= {tx_reg[6:0], 1'b0};
      end else if (scl_fall && bcnt_reg == 4'h8 && bus_reg != TKMOC_IDLE) begin
        bcnt_reg <= '0;
        ack_reg <= 1'b1;
        sda_oe <= 1'b1;
        unique case (bus_reg)
          TKMOC_ADDR: begin
            if (sh_reg[7:1] != BUS_ADDR) begin
              bus_reg <= TKMOC_IDLE;
              ack_reg <= 1'b0;
              sda_oe <= 1'b0;
            end else bus_reg <= sh_reg[0] ? TKMOC_RD : TKMOC_PTR;
          end
          TKMOC_PTR: begin
            ptr_reg <= sh_reg;
            bus_reg <= TKMOC_WR;
          end
          TKMOC_WR: begin
            wr_stb_reg <= 1'b1; // R13
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= sh_reg;
            ptr_reg <= ptr_reg + 8'h01;
          end
          default: bus_reg <= TKMOC_IDLE;
        endcase
      end
    end
  end
  // ==========================================================
  // checks
  a_idle_standby: assert property (@(posedge clk) disable iff (!nrst) // R3
    (mode_reg == TKMOC_NORMAL && key_rep_reg == 8'h00 && tick &&
     idle_cnt_reg == NORMAL_TO_STANDBY_MS - 16'h0001)
    |=> mode_reg == TKMOC_STANDBY ##1 standby_o)
    else $error("no standby after idle time");
  a_wake_cause: assert property (@(posedge clk) disable iff (!nrst) // R2
    (mode_reg == TKMOC_STANDBY ##1 mode_reg == TKMOC_NORMAL)
    |-> $past(key_rep_reg) != 8'h00)
    else $error("woke without a key");
  a_wake_mask: assert property (@(posedge clk) disable iff (!nrst) // R4
    (mode_reg == TKMOC_STANDBY && $changed(key_rep_reg))
    |-> (key_rep_reg & ~$past(wake_en)) == 8'h00)
    else $error("disabled key woke device");
  a_resp_time: assert property (@(posedge clk) disable iff (!nrst) // R5
    $changed(key_rep_reg) |-> $past(tick) &&
    $past(deb_cnt_reg) >= $past(resp_ms) - 16'h0001)
    else $error("key reported before response time");
  a_standby_resp: assert property (@(posedge clk) disable iff (!nrst) // R6
    mode_reg == TKMOC_STANDBY |->
    resp_ms == (low_save ? RESP_SAVE_MS : RESP_STANDBY_MS))
    else $error("wrong standby response time");
  a_hold_limit: assert property (@(posedge clk) disable iff (!nrst) // R7
    (tick && hold_cnt_reg == MAX_KEY_HOLD_MS - 16'h0001 &&
     key_rep_reg != 8'h00) |=> hold_block_reg != 8'h00)
    else $error("held key not blocked");
  a_cal_period: assert property (@(posedge clk) disable iff (!nrst) // R8
    cal_pulse |-> $past(cal_cnt_reg) == ($past(mode_reg) == TKMOC_NORMAL
    ? CAL_NORMAL_MS : CAL_STANDBY_MS) - 16'h0001)
    else $error("calibration period wrong");
  a_irq_level: assert property (@(posedge clk) disable iff (!nrst) // R11
    (!style_reg[STYLE_BIT] && key_rep_reg != 8'h00 && $stable(style_reg))
    |=> !irq_n)
    else $error("level interrupt not held");
  a_output_type: assert property (@(posedge clk) disable iff (!nrst) // R14
    mode_tied_reg |=> key_out_oe == 8'hFF && key_out_o == $past(key_rep_reg))
    else $error("push-pull output wrong");
  a_bin_code: assert property (@(posedge clk) disable iff (!nrst) // R15
    !mode_tied_reg |=> bin_code_o == 4'h0 && key_out_o == 8'h00)
    else $error("binary output in serial mode");
  a_bus_timeout: assert property (@(posedge clk) disable iff (!nrst) // R17
    to_cnt_reg >= BUS_TIMEOUT_MS |=> bus_reg == TKMOC_IDLE)
    else $error("bus transfer not abandoned");
  a_reg_zero: assert property (@(posedge clk) disable iff (!nrst) // R13
    wr_stb_reg && key_hit(wr_addr_reg) |=>
    key_cfg_reg[3'($past(wr_addr_reg) - OFF_KEY_BASE)][6] == 1'b0)
    else $error("key register bit6 not zero");
endmodule

// file: tkmoc_top_tb.sv
// self-checking bench of the touch-key mode and option control
module tkmoc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tkmoc_pkg::*;
  localparam int T = 2;
  logic clk, nrst, oms_n, lsc_n, scl, sda, lclk;
  logic sda_o, sda_oe, data_o, data_oe, irq_n, cal_pulse, standby_o;
  logic [7:0] keys, kout, koe, d, k;
  logic [3:0] bin;
  logic [15:0] f;
  int fail_count, check_count, cyc, n;
  logic [7:0] ra [5] = '{8'hB0, 8'hB4, 8'hB5, 8'hBC, 8'hBD};
  logic [7:0] rv [5] = '{8'h00, 8'h40, 8'h90, 8'h90, 8'h00};
  wire logic [7:0] rep = oms_n ? koe : kout;
  tkmoc_top #(.TICK_CYC(T)) i_dut (.clk(clk), .nrst(nrst),
    .key_touch(keys), .output_mode_select_n(oms_n),
    .low_standby_current_select_n(lsc_n), .link_clk(lclk), .scl_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .data_o(data_o),
    .data_oe(data_oe), .key_out_o(kout), .key_out_oe(koe),
    .bin_code_o(bin), .irq_n(irq_n), .cal_pulse(cal_pulse),
    .standby_o(standby_o));
  tkmoc_host #(.TICK(T)) i_host (.clk(clk), .sda_oe(sda_oe),
    .data_oe(data_oe), .scl(scl), .sda(sda), .link_clk(lclk));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] frame_of(input logic [7:0] x);
    return {4'hA, 4'($countones(x)), ~x};
  endfunction
  function automatic logic [3:0] low_key(input logic [7:0] x);
    low_key = 4'h0;
    for (int i = 7; i >= 0; i--) if (x[i]) low_key = 4'(i + 1);
  endfunction
  // touch pattern x, expect report e after about ms ticks
  task automatic touch(input logic [7:0] x, input logic [7:0] e,
                       input int ms, output logic ok);
    keys = x;
    n = 0;
    while (rep !== e && n < 2500 * T) begin
      @(negedge clk);
      n++;
    end
    ok = n >= (ms - 2) * T && n <= (ms + 2) * T + 6;
  endtask
  task automatic to_standby(output logic ok);
    n = 0;
    while (standby_o !== 1'b1 && n < 9500 * T) begin
      @(negedge clk);
      n++;
    end
    ok = n >= 7000 * T && n <= 9000 * T;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic ok;
    void'($urandom(32'hd23dc240));
    nrst = 1'b0;
    keys = 8'h00;
    oms_n = 1'b1;
    lsc_n = 1'b1;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (10) @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      i_host.reg_read(ra[i], d);
      chk(d, rv[i]);
    end
    // address byte left without its ack clock: the bus must give up
    i_host.edge_c(1'b0);
    d = {BUS_ADDR_DFLT, 1'b0};
    for (int i = 7; i >= 0; i--) i_host.put_bit(d[i], ok);
    repeat (8) @(negedge clk);
    chk(sda_oe, 1'b1);
    repeat (70 * T) @(negedge clk);
    chk({sda_oe, sda_o, data_o}, 3'h0);
    i_host.reg_write(8'hB5, 8'hFF);
    i_host.reg_read(8'hB5, d);
    chk(d, 8'hBF);
    i_host.reg_write(8'hBC, 8'h10);
    k = 8'($urandom) & 8'h7F | 8'h01;
    touch(k, k, int'(RESP_NORMAL_MS), ok);
    chk(ok, 1'b1);
    chk(kout, 8'h00);
    i_host.read_frame(f);
    chk(f, frame_of(k));
    chk(irq_n, 1'b0);
    while (cal_pulse !== 1'b1) @(negedge clk);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cal_pulse !== 1'b1 && n < 3000 * T);
    chk(16'(n), 16'(CAL_NORMAL_MS * T));
    touch(8'h00, 8'h00, int'(RESP_NORMAL_MS), ok);
    chk(ok, 1'b1);
    to_standby(ok);
    chk(ok, 1'b1);
    // key8 has no wake permission, so standby must hold
    keys = 8'h80;
    repeat (700 * T) @(negedge clk);
    chk({standby_o, rep}, 9'h100);
    touch(8'h81, 8'h01, int'(RESP_SAVE_MS), ok);
    chk(ok, 1'b1);
    // the mode flag follows the key outputs by one clock
    @(negedge clk);
    chk(standby_o, 1'b0);
    touch(8'h00, 8'h00, int'(RESP_NORMAL_MS), ok);
    to_standby(ok);
    i_host.reg_write(8'hB4, 8'h00);
    touch(8'h02, 8'h02, int'(RESP_STANDBY_MS), ok);
    chk(ok, 1'b1);
    // second power-up with both straps tied to ground
    nrst = 1'b0;
    keys = 8'h00;
    oms_n = 1'b0;
    lsc_n = 1'b0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    to_standby(ok);
    chk(ok, 1'b1);
    i_host.reg_write(8'hB4, 8'h00);
    i_host.reg_write(8'hB0, 8'h01);
    k = 8'($urandom) | 8'h80;
    touch(k, k, int'(RESP_SAVE_MS), ok);
    chk(ok, 1'b1);
    chk(koe, 8'hFF);
    // the one-shot is launched a clock after the key outputs
    @(negedge clk);
    chk(irq_n, 1'b0);
    chk(bin, low_key(k));
    repeat (3 * T) @(negedge clk);
    chk(irq_n, 1'b1);
    end_of_test();
  end
endmodule
